// ===== core/ufil_cfg.svh
// constants for the serial element interrupt, fifo status and line format block
// assumes a 16x receiver clock arrives on a pin and the fifos live outside
`ifndef UFIL_CFG_SVH
`define UFIL_CFG_SVH
// register addresses on the 3-bit plain port
`define UFIL_ADDR_DATA 3'h0
`define UFIL_ADDR_IEN 3'h1
`define UFIL_ADDR_IID 3'h2
`define UFIL_ADDR_LFC 3'h3
`define UFIL_ADDR_LST 3'h5
`define UFIL_ADDR_MST 3'h6
// interrupt enable bit positions
`define UFIL_IEN_RX 0
`define UFIL_IEN_TX 1
`define UFIL_IEN_LS 2
`define UFIL_IEN_MS 3
// identity codes, bits 3..0
`define UFIL_IID_NONE 4'h1
`define UFIL_IID_LS 4'h6
`define UFIL_IID_RX 4'h4
`define UFIL_IID_TO 4'hc
`define UFIL_IID_TX 4'h2
`define UFIL_IID_MS 4'h0
// line format fields
`define UFIL_LFC_STB 2
`define UFIL_LFC_PEN 3
// fifo control fields
`define UFIL_FCR_EN 0
`define UFIL_FCR_RXCLR 1
`define UFIL_FCR_TXCLR 2
// receiver trigger levels in bytes
`define UFIL_TRIG_0 5'h01
`define UFIL_TRIG_1 5'h04
`define UFIL_TRIG_2 5'h08
`define UFIL_TRIG_3 5'h0e
// timing in 16x ticks, timeout in character times
`define UFIL_TICKS_PER_BIT 8'h10
`define UFIL_TICKS_HALF_STOP 8'h18
`define UFIL_TICKS_TWO_STOP 8'h20
`define UFIL_TIMEOUT_CHARS 4
`define UFIL_RESET_BYTE 8'h00
`endif

// ===== core/ufil_pkg.sv
// types for the serial element interrupt, fifo status and line format block
// assumes nothing beyond the constants header
package ufil_pkg;
   // one register bus request, all signals of one cycle
   typedef struct packed {
      logic [2:0] addr;  // register address
      logic [7:0] wdata; // write data
      logic wr;          // write strobe
      logic rd;          // read strobe
   } ufil_bus_type;
   // pending sources; the identity ranks them ls, rx, to, tx, ms
   typedef struct packed {
      logic ls; // line status
      logic to; // character timeout
      logic rx; // data available
      logic tx; // holding empty
      logic ms; // modem status
   } ufil_pend_type;
endpackage

// ===== core/ufil_uart_fifo_interrupt_logic.sv
// interrupt, fifo status and line format logic of the serial element
// assumes fifos, shifters and modem latches outside on the same clock;
// the 16x receiver clock is a pin and is synchronised here
// How it works
// - timeout after four idle character times, fifo nonempty
// - second stop bit counts in timeout
// - character times counted on receiver clock
// - pending timeout cleared, timer restarted by read
// - push or read restarts idle timer
// - transmit empty interrupt, cleared by write/identity read
// - empty indication delayed in fifo mode unless two bytes held
// - first transmit interrupt after fifo toggle immediate
// - timeout/trigger share data priority; tx shares empty
// - polled mode: fifos buffer, no trigger/timeout indication
// - polled status: ready, empty, all empty, error
// - enable bits: data, empty, line, modem
// - unused enable and identity bits read zero
// - all enables clear silences interrupt output
// - priority line, data/timeout, empty, modem
// - identity bit 0 low while pending
// - identity codes show highest pending source
// - identity bit 3 only for fifo timeout
// - identity bits 7:6 follow fifo enable
// - status reads clear their own interrupts
// - word length field five to eight bits
// - stop select; receiver checks first stop only
// - stop bits 1.5 for five, else two
// - trigger level interrupt follows fill level
//
// Our own choices: the address-and-strobe port and the register offsets.
`include "ufil_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ufil_uart_fifo_interrupt_logic
   import ufil_pkg::*;
#(
   parameter int FIFO_DEPTH = 16 // bytes per fifo
) (
   input wire logic i_core_clk,            // core clock, 40 MHz
   input wire logic i_resetn,              // async reset, active low
   input wire ufil_bus_type i_bus,         // register bus request
   output logic [7:0] o_rdata,             // read data, cycle after read
   input wire logic i_rclk,                // 16x receiver clock pin
   input wire logic i_rx_push,             // char entered rx fifo, pulse
   input wire logic [4:0] i_rx_count,      // rx fifo fill level
   input wire logic [7:0] i_rx_data,       // rx fifo head byte
   input wire logic i_rx_fifo_err,         // error anywhere in rx fifo
   input wire logic [3:0] i_line_err,      // break, framing, parity, overrun
   input wire logic [4:0] i_tx_count,      // tx fifo fill level
   input wire logic i_tx_shift_empty,      // tx shift register empty
   input wire logic [7:0] i_modem_status,  // modem status byte
   output logic o_rx_pop,                  // rx buffer read, pulse
   output logic o_tx_push,                 // tx holding write, pulse
   output logic [7:0] o_tx_data,           // byte for tx fifo
   output logic o_line_status_read,        // line status read, pulse
   output logic o_modem_status_read,       // modem status read, pulse
   output logic [1:0] o_fifo_clear,        // bit1 tx, bit0 rx, pulse
   output logic o_fifo_enable_bit,         // fifo mode
   output logic [7:0] o_line_format,       // line format for rx and tx
   output logic [7:0] o_tx_stop_ticks,     // stop length for transmitter
   output logic o_interrupt_out            // interrupt, active high
);
   // refuse a depth the 5-bit levels and top trigger cannot serve
   initial begin
      if (FIFO_DEPTH < 14 || FIFO_DEPTH > 31) begin
         $error("FIFO_DEPTH out of range");
      end
   end

   // whole character length in 16x ticks, all stop bits included
   function automatic logic [7:0] char_ticks(input logic [7:0] lfc);
      logic [7:0] t;
      t = `UFIL_TICKS_PER_BIT * (8'h06 + {6'h00, lfc[1:0]});
      if (lfc[`UFIL_LFC_PEN]) begin
         t = t + `UFIL_TICKS_PER_BIT;
      end
      t = t + stop_ticks(lfc);
      return t;
   endfunction

   // stop length by select bit and word length
   function automatic logic [7:0] stop_ticks(input logic [7:0] lfc);
      logic [7:0] s;
      s = `UFIL_TICKS_PER_BIT;
      if (lfc[`UFIL_LFC_STB]) begin
         s = (lfc[1:0] == 2'b00) ? `UFIL_TICKS_HALF_STOP : `UFIL_TICKS_TWO_STOP;
      end
      return s;
   endfunction

   logic [7:0] ien_reg;      // interrupt enable bits
   logic [7:0] lfc_reg;      // line format control
   logic fen_reg;            // fifo enable
   logic [1:0] trig_reg;     // rx trigger select
   logic [7:0] rdata_reg;    // read data register
   logic int_reg;            // interrupt output register
   logic rx_pop_reg;         // rx read pulse
   logic tx_push_reg;        // tx write pulse
   logic [7:0] tx_data_reg;  // tx byte
   logic ls_rd_reg;          // line status read pulse
   logic ms_rd_reg;          // modem status read pulse
   logic [1:0] clr_reg;      // fifo clear pulses
   logic rclk_s1_reg;        // synchroniser first stage
   logic rclk_s2_reg;        // synchroniser second stage
   logic rclk_s3_reg;        // edge history
   logic [9:0] idle_reg;     // ticks since last push or read
   logic to_reg;             // timeout pending
   logic ind_reg;            // delayed tx empty indication
   logic ind_d_reg;          // indication one cycle ago
   logic [7:0] dly_reg;      // empty delay tick count
   logic two_seen_reg;       // two bytes held since last empty
   logic skip_reg;           // fifo toggle skips the delay
   logic tx_holding_empty_reg;           // holding empty interrupt flag

   logic tick;               // one 16x receiver tick
   logic rd_cyc;             // bus read this cycle
   logic wr_cyc;             // bus write this cycle
   logic rx_read;            // host read of rx buffer
   logic iid_read;           // host read of identity
   logic [4:0] trig_lvl;     // trigger level in bytes
   logic [9:0] to_limit;     // timeout length in ticks
   logic [7:0] tx_delay;     // empty indication delay
   logic tx_raw_empty;       // tx fifo holds nothing
   ufil_pend_type pend;      // enabled pending sources
   logic [3:0] iid_code;     // identity low nibble
   logic [7:0] iid_byte;     // full identity byte
   logic [7:0] lst_byte;     // full line status byte

   assign rd_cyc = i_bus.rd;
   assign wr_cyc = i_bus.wr;
   assign rx_read = rd_cyc && (i_bus.addr == `UFIL_ADDR_DATA);
   assign iid_read = rd_cyc && (i_bus.addr == `UFIL_ADDR_IID);
   assign to_limit = 10'(char_ticks(lfc_reg)) * 10'(`UFIL_TIMEOUT_CHARS);
   assign tx_delay = char_ticks(lfc_reg) - `UFIL_TICKS_PER_BIT;
   assign tx_raw_empty = (i_tx_count == 5'h00);
   assign tick = rclk_s2_reg && !rclk_s3_reg;

   // trigger level table
   always_comb begin
      unique case (trig_reg)
         2'b00: trig_lvl = `UFIL_TRIG_0;
         2'b01: trig_lvl = `UFIL_TRIG_1;
         2'b10: trig_lvl = `UFIL_TRIG_2;
         2'b11: trig_lvl = `UFIL_TRIG_3;
      endcase
   end

   // receiver clock pin crosses two flops before edge detection
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rclk_s1_reg <= 1'b0;
         rclk_s2_reg <= 1'b0;
         rclk_s3_reg <= 1'b0;
      end else begin
         rclk_s1_reg <= i_rclk;
         rclk_s2_reg <= rclk_s1_reg;
         rclk_s3_reg <= rclk_s2_reg;
      end
   end

   // software registers and the fifo control write
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ien_reg <= `UFIL_RESET_BYTE;
         lfc_reg <= `UFIL_RESET_BYTE;
         fen_reg <= 1'b0;
         trig_reg <= 2'b00;
         clr_reg <= 2'b00;
      end else begin
         clr_reg <= 2'b00;
         if (wr_cyc) begin
            unique case (i_bus.addr)
               `UFIL_ADDR_IEN: ien_reg <= {4'h0, i_bus.wdata[3:0]};
               `UFIL_ADDR_LFC: lfc_reg <= i_bus.wdata;
               `UFIL_ADDR_IID: begin
                  fen_reg <= i_bus.wdata[`UFIL_FCR_EN];
                  // toggling fifo mode empties both fifos
                  if (i_bus.wdata[`UFIL_FCR_EN] != fen_reg) begin
                     clr_reg <= 2'b11;
                  end else if (i_bus.wdata[`UFIL_FCR_EN]) begin
                     clr_reg <= {i_bus.wdata[`UFIL_FCR_TXCLR], i_bus.wdata[`UFIL_FCR_RXCLR]};
                  end
                  // other fields only take with the enable set
                  if (i_bus.wdata[`UFIL_FCR_EN]) begin
                     trig_reg <= i_bus.wdata[7:6];
                  end
               end
               default: ; // other addresses hold nothing here
            endcase
         end
      end
   end

   // access pulses and tx byte toward the fifos
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_pop_reg <= 1'b0;
         tx_push_reg <= 1'b0;
         tx_data_reg <= `UFIL_RESET_BYTE;
         ls_rd_reg <= 1'b0;
         ms_rd_reg <= 1'b0;
      end else begin
         rx_pop_reg <= rx_read;
         tx_push_reg <= wr_cyc && (i_bus.addr == `UFIL_ADDR_DATA);
         ls_rd_reg <= rd_cyc && (i_bus.addr == `UFIL_ADDR_LST);
         ms_rd_reg <= rd_cyc && (i_bus.addr == `UFIL_ADDR_MST);
         if (wr_cyc && (i_bus.addr == `UFIL_ADDR_DATA)) begin
            tx_data_reg <= i_bus.wdata;
         end
      end
   end

   // idle timer: any push or host read of the rx buffer restarts it
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idle_reg <= 10'h000;
      end else if (i_rx_push || rx_read) begin
         idle_reg <= 10'h000;
      end else if (tick && idle_reg < to_limit) begin
         idle_reg <= idle_reg + 10'h001;
      end
   end

   // timeout flag; a read clears it and restarts the timer, and clear wins over set in that cycle
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         to_reg <= 1'b0;
      end else if (!fen_reg || i_rx_count == 5'h00 || rx_read) begin
         to_reg <= 1'b0;
      end else if (idle_reg >= to_limit && !i_rx_push) begin
         to_reg <= 1'b1;
      end
   end

   // tx empty indication, delayed in fifo mode when only one byte was in flight
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ind_reg <= 1'b1;
         dly_reg <= 8'h00;
      end else if (!tx_raw_empty) begin
         ind_reg <= 1'b0;
         dly_reg <= 8'h00;
      end else if (!ind_reg) begin
         if (!fen_reg || two_seen_reg || skip_reg) begin
            ind_reg <= 1'b1;
         end else if (tick) begin
            if (dly_reg + 8'h01 >= tx_delay) begin
               ind_reg <= 1'b1;
            end else begin
               dly_reg <= dly_reg + 8'h01;
            end
         end
      end
   end

   // history for the empty delay: two bytes seen, fifo toggled
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         two_seen_reg <= 1'b0;
         skip_reg <= 1'b0;
         ind_d_reg <= 1'b1;
      end else begin
         ind_d_reg <= ind_reg;
         if (i_tx_count >= 5'h02) begin
            two_seen_reg <= 1'b1;
         end else if (ind_reg && !ind_d_reg) begin
            two_seen_reg <= 1'b0;
         end
         if (wr_cyc && i_bus.addr == `UFIL_ADDR_IID && i_bus.wdata[`UFIL_FCR_EN] != fen_reg) begin
            skip_reg <= 1'b1;
         end else if (ind_reg) begin
            skip_reg <= 1'b0;
         end
      end
   end

   // holding empty interrupt flag; a new empty edge beats a clear
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_holding_empty_reg <= 1'b0;
      end else if ((ind_reg && !ind_d_reg) || (skip_reg && ind_reg)) begin
         tx_holding_empty_reg <= 1'b1;
      end else if (tx_push_reg || (iid_read && iid_code == `UFIL_IID_TX)) begin
         tx_holding_empty_reg <= 1'b0;
      end
   end

   // enabled pending sources; cleared enables give polled mode
   always_comb begin
      pend.ls = ien_reg[`UFIL_IEN_LS] && (i_line_err != 4'h0);
      pend.to = ien_reg[`UFIL_IEN_RX] && fen_reg && to_reg;
      if (fen_reg) begin
         pend.rx = ien_reg[`UFIL_IEN_RX] && (i_rx_count >= trig_lvl);
      end else begin
         pend.rx = ien_reg[`UFIL_IEN_RX] && (i_rx_count != 5'h00);
      end
      pend.tx = ien_reg[`UFIL_IEN_TX] && tx_holding_empty_reg;
      pend.ms = ien_reg[`UFIL_IEN_MS] && (i_modem_status[3:0] != 4'h0);
   end

   // identity: highest pending source wins
   always_comb begin
      if (pend.ls) begin
         iid_code = `UFIL_IID_LS;
      end else if (pend.rx) begin
         iid_code = `UFIL_IID_RX;
      end else if (pend.to) begin
         iid_code = `UFIL_IID_TO;
      end else if (pend.tx) begin
         iid_code = `UFIL_IID_TX;
      end else if (pend.ms) begin
         iid_code = `UFIL_IID_MS;
      end else begin
         iid_code = `UFIL_IID_NONE;
      end
      iid_byte = {{2{fen_reg}}, 2'b00, iid_code};
   end

   // line status as polled software sees it
   always_comb begin
      lst_byte[0] = (i_rx_count != 5'h00);
      lst_byte[4:1] = i_line_err;
      lst_byte[5] = ind_reg;
      lst_byte[6] = ind_reg && i_tx_shift_empty;
      lst_byte[7] = fen_reg && i_rx_fifo_err;
   end

   // read data register, valid only in the cycle after the strobe
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_reg <= `UFIL_RESET_BYTE;
      end else if (rd_cyc) begin
         unique case (i_bus.addr)
            `UFIL_ADDR_DATA: rdata_reg <= i_rx_data;
            `UFIL_ADDR_IEN: rdata_reg <= ien_reg;
            `UFIL_ADDR_IID: rdata_reg <= iid_byte;
            `UFIL_ADDR_LFC: rdata_reg <= lfc_reg;
            `UFIL_ADDR_LST: rdata_reg <= lst_byte;
            `UFIL_ADDR_MST: rdata_reg <= i_modem_status;
            default: rdata_reg <= `UFIL_RESET_BYTE; // unmapped reads zero
         endcase
      end else begin
         rdata_reg <= `UFIL_RESET_BYTE;
      end
   end

   // interrupt output: any enabled source, so no enables means silent
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         int_reg <= 1'b0;
      end else begin
         int_reg <= (pend != '0);
      end
   end

   assign o_rdata = rdata_reg;
   assign o_rx_pop = rx_pop_reg;
   assign o_tx_push = tx_push_reg;
   assign o_tx_data = tx_data_reg;
   assign o_line_status_read = ls_rd_reg;
   assign o_modem_status_read = ms_rd_reg;
   assign o_fifo_clear = clr_reg;
   assign o_fifo_enable_bit = fen_reg;
   assign o_line_format = lfc_reg;
   assign o_tx_stop_ticks = stop_ticks(lfc_reg);
   assign o_interrupt_out = int_reg;
endmodule
`default_nettype wire

// ===== bench/ufil_props.sv
// concurrent checks on the ports of the interrupt, fifo status and line format block
// assumes the plain register bus with read data one cycle after the read strobe
`include "ufil_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ufil_props
   import ufil_pkg::*;
#(
   parameter int FIFO_DEPTH = 16 // bytes per fifo
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // async reset, active low
   input wire ufil_bus_type i_bus, // register request
   input wire logic [7:0] o_rdata, // read data
   input wire logic o_tx_push, // tx write pulse
   input wire logic [7:0] o_tx_data, // tx byte
   input wire logic o_fifo_enable_bit, // fifo mode
   input wire logic [7:0] o_line_format, // line format
   input wire logic [7:0] o_tx_stop_ticks, // stop length
   input wire logic o_interrupt_out // interrupt
);
   default clocking dc @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   // a read or a write at one address
   sequence s_rd(logic [2:0] a);
      i_bus.rd && i_bus.addr == a;
   endsequence
   sequence s_wr(logic [2:0] a);
      i_bus.wr && i_bus.addr == a;
   endsequence
   // all four enables cleared, then left alone while the output settles
   sequence s_ien_off;
      s_wr(`UFIL_ADDR_IEN) ##0 i_bus.wdata[3:0] == 4'h0
         ##1 !(i_bus.wr && i_bus.addr == `UFIL_ADDR_IEN) [*2];
   endsequence
   chk_ien_upper: assert property (s_rd(`UFIL_ADDR_IEN) |=> o_rdata[7:4] == 4'h0)
      else $error("enable read shows unused bits");
   chk_iid_unused: assert property (s_rd(`UFIL_ADDR_IID) |=> o_rdata[5:4] == 2'b00)
      else $error("identity read shows unused bits");
   chk_iid_mode: assert property (s_rd(`UFIL_ADDR_IID) |=>
      o_rdata[7:6] == {2{$past(o_fifo_enable_bit)}}) else $error("identity mode bits wrong");
   chk_timeout_code: assert property (s_rd(`UFIL_ADDR_IID) |=>
      !o_rdata[3] || (o_rdata[2] && o_rdata[7])) else $error("identity bit 3 misused");
   chk_ien_off: assert property (s_ien_off |-> !o_interrupt_out)
      else $error("interrupt out with all enables clear");
   chk_stop_len: assert property (o_tx_stop_ticks == (!o_line_format[2] ? 8'h10 :
      (o_line_format[1:0] == 2'b00 ? 8'h18 : 8'h20))) else $error("stop length wrong");
   chk_lfc_write: assert property (s_wr(`UFIL_ADDR_LFC) |=>
      o_line_format == $past(i_bus.wdata)) else $error("line format not stored");
   chk_tx_write: assert property (s_wr(`UFIL_ADDR_DATA) |=>
      o_tx_push && o_tx_data == $past(i_bus.wdata)) else $error("tx write not passed on");
endmodule
bind ufil_uart_fifo_interrupt_logic ufil_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_bus(i_bus), .o_rdata(o_rdata),
   .o_tx_push(o_tx_push), .o_tx_data(o_tx_data), .o_fifo_enable_bit(o_fifo_enable_bit),
   .o_line_format(o_line_format), .o_tx_stop_ticks(o_tx_stop_ticks),
   .o_interrupt_out(o_interrupt_out));
`default_nettype wire

// ===== bench/ufil_far_model.sv
// far-side model: rx and tx fifos, tx shifter and a free 16x receiver clock
// assumes the block's core clock; clears and pops arrive as its pulses
`timescale 1ns/100ps
`default_nettype none
module ufil_far_model #(
   parameter int DRAIN = 40 // core cycles per byte sent, a slow line
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // reset, active low
   input wire logic i_push_req, // bench hands in a received char
   input wire logic i_rx_pop, // rx buffer read
   input wire logic i_tx_push, // tx holding write
   input wire logic [1:0] i_fifo_clear, // {tx,rx} clears
   output logic o_rx_push, // char entered rx fifo
   output logic [4:0] o_rx_count, // rx fill
   output logic [7:0] o_rx_data, // rx head byte
   output logic [4:0] o_tx_count, // tx fill
   output logic o_tx_shift_empty, // shifter idle
   output logic o_rclk = 1'b0 // receiver clock, free running
);
   logic [7:0] busy_reg; // cycles left on the byte in the shifter
   logic load; // shifter takes a byte
   logic pop; // pop that finds a byte
   // edges kept off the rising core clock edges so the sync never races
   always #25 o_rclk = ~o_rclk;
   assign load = (busy_reg == 8'h00) && (o_tx_count != 5'h00);
   assign pop = i_rx_pop && (o_rx_count != 5'h00);
   assign o_tx_shift_empty = (busy_reg == 8'h00);
   // rx side: head byte moves on with each pop
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_push <= 1'b0;
         o_rx_count <= 5'h00;
         o_rx_data <= 8'h00;
      end else begin
         o_rx_push <= i_push_req;
         o_rx_data <= o_rx_data + {7'h0, pop};
         o_rx_count <= i_fifo_clear[0] ? 5'h00 : o_rx_count + {4'h0, o_rx_push} - {4'h0, pop};
      end
   end
   // tx side: slow drain, so the block sees the fifo fill and empty
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_tx_count <= 5'h00;
         busy_reg <= 8'h00;
      end else begin
         o_tx_count <= i_fifo_clear[1] ? 5'h00 : o_tx_count + {4'h0, i_tx_push} - {4'h0, load};
         busy_reg <= load ? 8'(DRAIN) : busy_reg - {7'h0, !o_tx_shift_empty};
      end
   end
endmodule
`default_nettype wire

// ===== bench/ufil_uart_fifo_interrupt_logic_tb.sv
// self-checking bench for the interrupt, fifo status and line format block
// assumes the far-side model file and the bound checker are compiled first
`include "ufil_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define expect_eq(act, exp) begin \
   checks++; \
   if ((act) !== (exp)) begin \
      fails++; \
      $display("unexpected at %0t: got %h expected %h", $time, (act), (exp)); \
   end \
end
module ufil_uart_fifo_interrupt_logic_tb
   import ufil_pkg::*;
;
   logic clk = 1'b0, resetn, push_req, rx_err; // clock, reset and bench levels
   ufil_bus_type bus; // register request
   logic [7:0] rdata, modem, rx_data, stop, v; // data paths
   logic [3:0] line_err; // line error levels
   logic rx_push, rx_pop, tx_push, int_out, rclk, shift_empty; // handshakes
   logic [4:0] rx_count, tx_count; // fifo levels
   logic [1:0] fclr; // fifo clear pulses
   integer fails, checks, seed, i; // counters, seed, loop index
   logic [31:0] r; // random word
   always #12.5 clk = ~clk;
   ufil_uart_fifo_interrupt_logic #(.FIFO_DEPTH(16)) i_dut (
      .i_core_clk(clk), .i_resetn(resetn), .i_bus(bus), .o_rdata(rdata), .i_rclk(rclk),
      .i_rx_push(rx_push), .i_rx_count(rx_count), .i_rx_data(rx_data),
      .i_rx_fifo_err(rx_err), .i_line_err(line_err), .i_tx_count(tx_count),
      .i_tx_shift_empty(shift_empty), .i_modem_status(modem), .o_rx_pop(rx_pop),
      .o_tx_push(tx_push), .o_tx_data(), .o_line_status_read(), .o_modem_status_read(),
      .o_fifo_clear(fclr), .o_fifo_enable_bit(), .o_line_format(),
      .o_tx_stop_ticks(stop), .o_interrupt_out(int_out));
   ufil_far_model i_far (.i_core_clk(clk), .i_resetn(resetn), .i_push_req(push_req),
      .i_rx_pop(rx_pop), .i_tx_push(tx_push), .i_fifo_clear(fclr), .o_rx_push(rx_push),
      .o_rx_count(rx_count), .o_rx_data(rx_data), .o_tx_count(tx_count),
      .o_tx_shift_empty(shift_empty), .o_rclk(rclk));
   // expected identity byte
   function automatic logic [7:0] f_iid(input logic fe, input logic [3:0] code);
      return {fe, fe, 2'b00, code};
   endfunction
   // expected stop length in 16x ticks
   function automatic logic [7:0] f_stop(input logic [7:0] lf);
      return !lf[2] ? 8'h10 : (lf[1:0] == 2'b00 ? 8'h18 : 8'h20);
   endfunction
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask
   // data taken mid-cycle after the request, ends on a rising edge
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic rx_char();
      @(posedge clk);
      push_req <= 1'b1;
      @(posedge clk);
      push_req <= 1'b0;
   endtask
   // bounded wait for the interrupt output
   task automatic wait_int(input integer lim);
      integer n;
      n = 0;
      while (int_out !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog, well beyond the sum of the long waits below
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end
   initial begin
      resetn = 1'b0;
      bus = '0;
      {push_req, rx_err, line_err, modem} = '0;
      fails = 0;
      checks = 0;
      seed = 32'he6ca70e9;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b0, `UFIL_IID_NONE))
      bus_rd(3'h7, v);
      `expect_eq(v, 8'h00)
      // random enables, every word length with and without the stop select
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         bus_wr(`UFIL_ADDR_IEN, r[7:0]);
         bus_rd(`UFIL_ADDR_IEN, v);
         `expect_eq(v, {4'h0, r[3:0]})
         bus_wr(`UFIL_ADDR_LFC, {r[15:11], i[2:0]});
         bus_rd(`UFIL_ADDR_LFC, v);
         `expect_eq(v, {r[15:11], i[2:0]})
         `expect_eq(stop, f_stop(v))
      end
      // entering fifo mode gives the transmit interrupt at once
      bus_wr(`UFIL_ADDR_LFC, 8'h03);
      bus_wr(`UFIL_ADDR_IEN, 8'h02);
      bus_rd(`UFIL_ADDR_IID, v);
      bus_wr(`UFIL_ADDR_IID, 8'h01);
      wait_int(8);
      `expect_eq(int_out, 1'b1)
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_TX))
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_NONE))
      // three bytes in one service, then empty again after the drain
      for (i = 0; i < 3; i++)
         bus_wr(`UFIL_ADDR_DATA, r[23:16] + i[7:0]);
      wait_int(3000);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_TX))
      // lone byte: empty shown a character less one bit late
      bus_wr(`UFIL_ADDR_DATA, r[31:24]);
      wait_int(200);
      `expect_eq(int_out, 1'b0)
      wait_int(200);
      `expect_eq(int_out, 1'b1)
      // line beats data, data beats modem; the bench drops line and modem, a data read clears data
      bus_wr(`UFIL_ADDR_IEN, 8'h0d);
      line_err <= 4'h4;
      modem <= 8'h01;
      rx_char();
      repeat (4) @(posedge clk);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_LS))
      line_err <= 4'h0;
      bus_rd(`UFIL_ADDR_LST, v);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_RX))
      bus_rd(`UFIL_ADDR_DATA, v);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_MS))
      modem <= 8'h00;
      bus_rd(`UFIL_ADDR_MST, v);
      line_err <= 4'h1;
      bus_wr(`UFIL_ADDR_IEN, 8'h00);
      repeat (3) @(posedge clk);
      `expect_eq(int_out, 1'b0)
      line_err <= 4'h0;
      // timeout: second arrival restarts it, two stop bits lengthen it
      bus_wr(`UFIL_ADDR_LFC, 8'h07);
      bus_wr(`UFIL_ADDR_IID, 8'hc1);
      bus_wr(`UFIL_ADDR_IEN, 8'h01);
      rx_char();
      repeat (1000) @(posedge clk);
      rx_char();
      repeat (1300) @(posedge clk);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_NONE))
      repeat (180) @(posedge clk);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_TO))
      bus_rd(`UFIL_ADDR_DATA, v);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_NONE))
      // polled mode: no timeout shown, status still reported
      bus_wr(`UFIL_ADDR_IEN, 8'h00);
      rx_err <= 1'b1;
      repeat (1500) @(posedge clk);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v, f_iid(1'b1, `UFIL_IID_NONE))
      bus_rd(`UFIL_ADDR_LST, v);
      `expect_eq(v & 8'hc1, 8'hc1)
      bus_wr(`UFIL_ADDR_IID, 8'h00);
      bus_rd(`UFIL_ADDR_IID, v);
      `expect_eq(v[7:6], 2'b00)
      conclude();
   end
endmodule
`default_nettype wire
